// ---- dv/sac_link_props.sv ----
// sac_link_props: timing checks on the serial link between host and device.
// assumes one system clock domain; sees only the link lines, no bind.
`timescale 1ns/100ps
module sac_link_props (
  input wire logic clock,    // system clock
  input wire logic sys_rst,  // async reset, active high
  input wire logic cs_n,     // chip select, active low
  input wire logic io_clk,   // serial clock
  input wire logic addr_in,  // serial address bit
  input wire logic data_out, // serial data from device
  input wire logic data_oe,  // device drives data line
  input wire logic eoc       // conversion done flag
);
  logic [2:0] fall_cnt;  // serial clock falls within the frame
  logic       io_q;      // serial clock one cycle back
  logic       cs_q;      // select one cycle back
  logic [9:0] since;     // cycles since eighth fall, saturating
  logic       conv_live; // conversion started and not reset since
  wire        eighth = !cs_n && io_q && !io_clk && (fall_cnt == 3'h7); // eighth fall of a frame

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // edge memory; select resets high to match the host idle level
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      io_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      io_q <= io_clk;
      cs_q <= cs_n;
    end
  end

  // frame position; wraps at eight so held-low select keeps framing
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) fall_cnt <= 3'h0;
    else if (cs_n) fall_cnt <= 3'h0;
    else if (io_q && !io_clk) fall_cnt <= fall_cnt + 3'h1;
  end

  // a raw select fall clears the flag early, so an abort never looks like a short conversion
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) conv_live <= 1'b0;
    else if (cs_q && !cs_n) conv_live <= 1'b0;
    else if (eighth) conv_live <= 1'b1;
  end

  // conversion age counter
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) since <= 10'h3FF;
    else if (eighth) since <= 10'h000;
    else if (since != 10'h3FF) since <= since + 10'h001;
  end

  sequence s_desel;
    cs_n [*6];
  endsequence

  sequence s_select;
    s_desel ##1 !cs_n;
  endsequence

  a_desel_off: assert property (s_desel |-> !data_oe)
    else $error("data line driven while deselected");
  a_filter_wait: assert property (s_select |-> !data_oe [*8])
    else $error("select accepted before filter delay");
  a_msb_prompt: assert property (s_select |-> ##[1:100] data_oe)
    else $error("previous msb not driven after select");
  a_data_hold: assert property (io_clk [*5] |-> $stable(data_out))
    else $error("data changed while serial clock high");
  a_addr_stable: assert property ($rose(io_clk) |-> $stable(addr_in))
    else $error("address bit changed with serial clock rise");
  a_eoc_falls: assert property (eighth |-> ##[1:8] !eoc)
    else $error("done flag not lowered after eighth fall");
  a_eoc_cause: assert property ($fell(eoc) |-> conv_live && since <= 10'd10)
    else $error("done flag fell without an eighth fall");
  a_conv_length: assert property ($rose(eoc) && conv_live |-> since >= 10'd560 && since <= 10'd600)
    else $error("conversion length off");
  a_conv_bound: assert property (conv_live && since == 10'd620 |-> eoc)
    else $error("conversion not finished in time");
endmodule

// ---- dv/serial_adc_control_sequencer_tb.sv ----
// serial_adc_control_sequencer_tb: host and device joined, frames run per channel.
// assumes the host keeps the link timing; analog levels are driven as codes.
`timescale 1ns/100ps
module serial_adc_control_sequencer_tb import sac_pkg::*;;
  logic       clock = 1'b0;       // system clock
  logic       sys_rst = 1'b1;     // reset, active high
  logic       req = 1'b0;         // frame request pulse
  logic [3:0] chan = 4'h0;        // channel address
  logic       release_cs = 1'b0;  // raise select after frame
  logic [7:0] analog_in = 8'h00;  // code of selected input
  logic       over_range = 1'b0;  // input above upper reference
  logic       under_range = 1'b0; // input below lower reference
  logic [3:0] mux_sel;            // channel seen by front end
  logic       sampling;           // sample switch
  logic [7:0] result;             // last completed result
  logic       busy;               // host frame in progress
  logic [7:0] rx_data;            // result read by host
  logic       rx_valid;           // read pulse
  logic [7:0] prev;               // result due in next frame
  int         err_count = 0;      // mismatches
  int         num_checks = 0;     // comparisons made
  int         i;                  // channel loop

  sac_link_if link();
  sac_device u_sac_device (.clock(clock), .sys_rst(sys_rst), .link(link),
    .over_range(over_range), .under_range(under_range), .analog_in(analog_in),
    .mux_sel(mux_sel), .sampling(sampling), .result(result));
  sac_host u_sac_host (.clock(clock), .sys_rst(sys_rst), .link(link), .req(req), .chan(chan),
    .release_cs(release_cs), .busy(busy), .rx_data(rx_data), .rx_valid(rx_valid));
  sac_link_props u_sac_link_props (.clock(clock), .sys_rst(sys_rst), .cs_n(link.cs_n), .io_clk(link.io_clk),
    .addr_in(link.addr_in), .data_out(link.data_out), .data_oe(link.data_oe), .eoc(link.eoc));

  always #4 clock = ~clock;

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one host frame; analog levels held until the host is idle again
  task automatic run_frame(input logic [3:0] ch, input logic rel, input logic [7:0] an, input logic ov,
                           input logic un, input logic [7:0] exp_res);
    int   n;
    logic seen;
    seen = 1'b0;
    @(posedge clock);
    #1;
    chan = ch;
    release_cs = rel;
    analog_in = an;
    over_range = ov;
    under_range = un;
    req = 1'b1;
    @(posedge clock);
    #1;
    req = 1'b0;
    for (n = 0; n < 8000 && (n == 0 || busy !== 1'b0); n++) begin
      @(posedge clock);
      #1;
      if (rx_valid === 1'b1) begin
        seen = 1'b1;
        chk_byte(rx_data, prev, "read data");
        chk_bit(sampling, 1'b1, "sampling");
      end
    end
    if (n >= 8000) begin
      err_count++;
      $display("MISMATCH t=%0t frame did not end", $time);
      tally_and_finish();
    end else begin
      repeat (8) @(posedge clock);
      #1;
      chk_bit(seen, 1'b1, "frame read");
      chk_byte({4'h0, mux_sel}, {4'h0, ch}, "channel");
      chk_byte(result, exp_res, "result");
      chk_bit(link.eoc, 1'b1, "done flag");
      chk_bit(sampling, 1'b0, "holding");
      chk_bit(link.data_oe, !rel, "data drive");
      if (!rel) chk_bit(link.data_out, exp_res[7], "new msb");
      if (ch == SELF_TEST_ADDR) chk_bit(result >= SELF_TEST_LO && result <= SELF_TEST_HI, 1'b1, "self test");
      prev = exp_res;
    end
  endtask

  initial begin
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk_byte(result, RESULT_RESET, "reset result");
    chk_bit(link.eoc, 1'b1, "reset done");
    chk_bit(link.data_oe, 1'b0, "reset drive");
    prev = RESULT_RESET;
    // every input plus self test; select alternates between held and released
    for (i = 0; i <= EXT_CHANNELS; i++) begin
      run_frame(i[3:0], i[0], 8'(i * 23 + 5), 1'b0, 1'b0,
                (i == SELF_TEST_ADDR) ? SELF_TEST_CODE : 8'(i * 23 + 5));
    end
    $display("test channels done");
    run_frame(4'h2, 1'b0, 8'h40, 1'b1, 1'b0, CODE_FULL);
    run_frame(4'h2, 1'b1, 8'h40, 1'b0, 1'b1, CODE_ZERO);
    run_frame(4'h5, 1'b1, 8'h3C, 1'b0, 1'b0, 8'h3C);
    $display("test clamp done");
    tally_and_finish();
  end
endmodule

// ---- hw/sac_device.sv ----
// sac_device: converter control sequencer, device end of the serial link.
// assumes host keeps its own timing; analog value arrives as a sampled code.
`timescale 1ns/100ps
// Contract
// - chip select high: output off, inputs ignored
// - accept low after two rises, one fall
// - drive previous MSB once select recognised
// - capture address MSB first, four rises
// - first four falls shift bits two-five
// - falls five-seven shift bits six-eight
// - sample new input after fourth fall
// - eighth fall holds and starts conversion
// - host waits 20 us after eighth pulse
// - frames repeat with select held low
// - host holds select high until done
// - recognised select fall resets, aborts conversion
// - early new frame aborts, restarts conversion
// - done flag low at eighth fall
// - done flag high when result ready
// - address 1011 selects self-test code
// - clamp over and under range codes
// - any of eleven inputs, any order
// - full cycle repeatable every 40 us
// - conversion lasts 36 internal clock periods
module sac_device import sac_pkg::*; #(
  parameter int unsigned DIV = SYS_DIV  // internal system clock divider
) (
  input  wire logic        clock,       // system clock
  input  wire logic        sys_rst,     // async reset, active high
  sac_link_if.device       link,        // serial link
  input  wire logic        over_range,  // sampled input above upper reference
  input  wire logic        under_range, // sampled input below lower reference
  input  wire logic [7:0]  analog_in,   // raw code of selected channel
  output logic [3:0]       mux_sel,     // selected channel to analog front end
  output logic             sampling,    // sample switch closed
  output logic [7:0]       result       // last completed result
);
  typedef enum logic [1:0] {
    SAC_OFF   = 2'b00,  // select high or not yet recognised
    SAC_ARM   = 2'b01,  // filtering the falling select
    SAC_FRAME = 2'b10   // shifting a frame
  } sac_state_e;

  localparam int unsigned CONV_CNT = CONV_SYS_CLKS * DIV; // system cycles per conversion
  localparam int unsigned DIV_W    = $clog2(DIV);

  logic             cs_s;      // synchronised chip select
  logic             clk_s;     // synchronised serial clock
  logic             adr_s;     // synchronised address bit
  logic             clk_d;     // previous serial clock
  logic [DIV_W-1:0] div_cnt;   // internal clock divider
  logic             ick;       // internal clock level
  logic             ick_d;     // previous internal clock
  logic [1:0]       rise_cnt;  // internal rises seen during filter
  sac_state_e       state;     // link state
  logic [2:0]       bit_cnt;   // serial clock count within frame
  logic [3:0]       addr_sr;   // incoming address
  logic [7:0]       shift;     // outgoing result bits
  logic [3:0]       conv_addr; // channel held for conversion
  logic             conv_run;  // conversion in progress
  logic [15:0]      conv_cnt;  // conversion timer
  logic [7:0]       conv_code; // code computed at end of conversion
  logic             io_rise;   // serial clock rising
  logic             io_fall;   // serial clock falling
  logic             ick_rise;  // internal clock rising
  logic             ick_fall;  // internal clock falling
  logic             frame_end; // eighth falling edge
  logic             cs_fall;   // recognised select fall

  sac_sync u_cs  (.clock(clock), .sys_rst(sys_rst), .din(link.cs_n),    .dout(cs_s));
  sac_sync u_clk (.clock(clock), .sys_rst(sys_rst), .din(link.io_clk),  .dout(clk_s));
  sac_sync u_adr (.clock(clock), .sys_rst(sys_rst), .din(link.addr_in), .dout(adr_s));

  assign io_rise   = (state == SAC_FRAME) && clk_s && !clk_d;
  assign io_fall   = (state == SAC_FRAME) && !clk_s && clk_d;
  assign ick_rise  = ick && !ick_d;
  assign ick_fall  = !ick && ick_d;
  assign frame_end = io_fall && (bit_cnt == 3'(FRAME_CLKS - 1));
  assign cs_fall   = (state == SAC_ARM) && ick_fall && (rise_cnt == 2'h2);

  // internal system clock: free-running divided square wave
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= '0;
      ick     <= 1'b0;
      ick_d   <= 1'b0;
      clk_d   <= 1'b0;
    end else begin
      ick_d   <= ick;
      clk_d   <= clk_s;
      if (div_cnt == DIV_W'(DIV / 2 - 1)) begin
        div_cnt <= '0;
        ick     <= ~ick;
      end else begin
        div_cnt <= div_cnt + DIV_W'(1);
      end
    end
  end

  // select filter and frame state; select high always drops to off
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= SAC_OFF;
      rise_cnt <= 2'h0;
    end else if (cs_s) begin
      state    <= SAC_OFF;
      rise_cnt <= 2'h0;
    end else begin
      unique case (state)
        SAC_OFF: begin
          state    <= SAC_ARM;
          rise_cnt <= 2'h0;
        end
        SAC_ARM: begin
          if (ick_rise && rise_cnt != 2'h2) begin
            rise_cnt <= rise_cnt + 2'h1;
          end
          if (cs_fall) begin
            state <= SAC_FRAME;
          end
        end
        SAC_FRAME: begin
          state <= SAC_FRAME;
        end
        // unused code 2'b11: fall back to off and refilter select
        default: begin
          state <= SAC_OFF;
        end
      endcase
    end
  end

  // frame counter, address capture and result shifting
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt <= 3'h0;
      addr_sr <= 4'h0;
      shift   <= RESULT_RESET;
    end else if (cs_fall || state != SAC_FRAME) begin
      bit_cnt <= 3'h0;
      shift   <= result;
    end else begin
      if (io_rise && bit_cnt < 3'(ADDR_BITS)) begin
        addr_sr <= {addr_sr[2:0], adr_s};
      end
      if (io_fall) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift   <= {shift[6:0], 1'b0};
      end
      if (frame_end) begin
        shift <= result;
      end
      if (conv_run && conv_cnt == 16'(CONV_CNT - 1)) begin
        shift <= conv_code;
      end
    end
  end

  // data pin: driven only in a recognised frame
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      link.data_oe  <= 1'b0;
      link.data_out <= 1'b0;
    end else begin
      link.data_oe  <= (state == SAC_FRAME) && !cs_s;
      link.data_out <= shift[7];
    end
  end

  // result code with clamping and self-test channel
  always_comb begin
    if (conv_addr == SELF_TEST_ADDR) begin
      conv_code = SELF_TEST_CODE;
    end else if (over_range) begin
      conv_code = CODE_FULL;
    end else if (under_range) begin
      conv_code = CODE_ZERO;
    end else begin
      conv_code = analog_in;
    end
  end

  // sampling, conversion timer and done flag
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sampling  <= 1'b0;
      conv_run  <= 1'b0;
      conv_cnt  <= 16'h0;
      conv_addr <= 4'h0;
      mux_sel   <= 4'h0;
      link.eoc  <= 1'b1;
      result    <= RESULT_RESET;
    end else if (cs_fall) begin
      sampling  <= 1'b0;
      conv_run  <= 1'b0;
      conv_cnt  <= 16'h0;
    end else begin
      if (io_fall && bit_cnt == 3'(ADDR_BITS - 1)) begin
        sampling <= 1'b1;
        mux_sel  <= addr_sr;
      end
      if (frame_end) begin
        sampling  <= 1'b0;
        conv_addr <= mux_sel;
        conv_run  <= 1'b1;
        conv_cnt  <= 16'h0;
        link.eoc  <= 1'b0;
      end else if (conv_run) begin
        if (conv_cnt == 16'(CONV_CNT - 1)) begin
          conv_run <= 1'b0;
          result   <= conv_code;
          link.eoc <= 1'b1;
        end else begin
          conv_cnt <= conv_cnt + 16'h1;
        end
      end
    end
  end
endmodule

// ---- hw/sac_host.sv ----
// sac_host: host end; runs one frame per request on the serial link.
// assumes device follows the link contract; serial clock made by divider.
`timescale 1ns/100ps
module sac_host import sac_pkg::*; (
  input  wire logic       clock,     // system clock
  input  wire logic       sys_rst,   // async reset, active high
  sac_link_if.host        link,      // serial link
  input  wire logic       req,       // start frame, pulse
  input  wire logic [3:0] chan,      // channel address for new conversion
  input  wire logic       release_cs,// raise select after the frame
  output logic            busy,      // frame or wait in progress
  output logic [7:0]      rx_data,   // previous conversion result
  output logic            rx_valid   // rx_data fresh, one-cycle pulse
);
  typedef enum logic [2:0] {
    SAH_IDLE  = 3'b000,  // waiting for request
    SAH_SETUP = 3'b001,  // select low, setup wait
    SAH_CLK   = 3'b010,  // shifting eight pulses
    SAH_WAIT  = 3'b011   // conversion time
  } sah_state_e;

  sah_state_e  state;   // host state
  logic [15:0] cnt;     // timing counter
  logic [3:0]  bits;    // serial clock pulses done
  logic [3:0]  addr;    // address shifter
  logic [7:0]  rx;      // receive shifter
  logic        hold_cs; // keep select low after frame
  logic        din_s;   // synchronised data line

  // released data line reads high, as if pulled up, so a stale bit never shifts in
  sac_sync u_din (.clock(clock), .sys_rst(sys_rst), .din(link.data_out | !link.data_oe), .dout(din_s));

  // sequence: select, setup if select was high, 8 clocks, wait out conversion
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= SAH_IDLE;
      cnt         <= 16'h0;
      bits        <= 4'h0;
      addr        <= 4'h0;
      rx          <= 8'h00;
      hold_cs     <= 1'b0;
      link.cs_n   <= 1'b1;
      link.io_clk <= 1'b0;
      link.addr_in<= 1'b0;
      busy        <= 1'b0;
      rx_data     <= 8'h00;
      rx_valid    <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      unique case (state)
        SAH_IDLE: begin
          if (req) begin
            busy      <= 1'b1;
            addr      <= chan;
            hold_cs   <= !release_cs;
            cnt       <= 16'h0;
            state     <= link.cs_n ? SAH_SETUP : SAH_CLK;
            link.cs_n <= 1'b0;
          end
        end
        SAH_SETUP: begin
          cnt <= cnt + 16'h1;
          if (cnt == 16'(CS_SETUP_CLKS)) begin
            cnt   <= 16'h0;
            state <= SAH_CLK;
          end
        end
        SAH_CLK: begin
          cnt <= cnt + 16'h1;
          if (cnt == 16'(HOST_HALF_CLKS - 1)) begin
            cnt <= 16'h0;
            if (!link.io_clk) begin
              // address stays put across the rise: both lines pass equal synchronisers
              link.io_clk  <= 1'b1;
              rx           <= {rx[6:0], din_s};
            end else begin
              link.io_clk <= 1'b0;
              bits        <= bits + 4'h1;
              if (bits == 4'(FRAME_CLKS - 1)) begin
                state <= SAH_WAIT;
              end
            end
          end else if (cnt == 16'h0 && !link.io_clk) begin
            link.addr_in <= (bits < 4'(ADDR_BITS)) ? addr[3] : 1'b0;
            if (bits < 4'(ADDR_BITS)) begin
              addr <= {addr[2:0], 1'b0};
            end
          end
        end
        SAH_WAIT: begin
          cnt <= cnt + 16'h1;
          if (cnt == 16'h0) begin
            rx_data   <= rx;
            rx_valid  <= 1'b1;
            link.cs_n <= !hold_cs;
          end
          if (cnt == 16'(HOST_WAIT_CLKS)) begin
            state <= SAH_IDLE;
            bits  <= 4'h0;
            cnt   <= 16'h0;
            busy  <= 1'b0;
          end
        end
        default: state <= SAH_IDLE;
      endcase
    end
  end
endmodule

// ---- hw/sac_link_if.sv ----
// sac_link_if: serial control link between host and converter.
// assumes the host reads the data line as high while data_oe is low, like a pull-up.
`timescale 1ns/100ps
interface sac_link_if;
  logic cs_n;      // chip select, active low
  logic io_clk;    // serial clock from host
  logic addr_in;   // serial address bit
  logic data_out;  // serial data from device
  logic data_oe;   // device drives data line
  logic eoc;       // conversion done flag
  modport device (input cs_n, input io_clk, input addr_in, output data_out, output data_oe, output eoc);
  modport host   (output cs_n, output io_clk, output addr_in, input data_out, input data_oe, input eoc);
endinterface

// ---- hw/sac_pkg.sv ----
// sac_pkg: shared constants of the serial converter control link.
// assumes both ends run on the same 125 MHz system clock.
package sac_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 8;       // system clock period
  localparam int unsigned CONV_TIME_US    = 20;      // longest conversion time
  localparam int unsigned CONV_CYCLES     = (CONV_TIME_US * 1000) / CLK_PERIOD_NS; // rounds down
  localparam int unsigned SYS_DIV         = 16;      // device internal system clock divider
  localparam int unsigned CONV_SYS_CLKS   = 36;      // internal clock periods per conversion
  localparam int unsigned ADDR_BITS       = 4;       // channel address width
  localparam int unsigned DATA_BITS       = 8;       // result width
  localparam int unsigned FRAME_CLKS      = 8;       // serial clocks per frame
  localparam int unsigned EXT_CHANNELS    = 11;      // external analog inputs
  localparam logic [3:0]  SELF_TEST_ADDR  = 4'hB;    // self-test channel address
  localparam logic [7:0]  SELF_TEST_LO    = 8'h7D;   // self-test code lower bound
  localparam logic [7:0]  SELF_TEST_HI    = 8'h83;   // self-test code upper bound
  localparam logic [7:0]  SELF_TEST_CODE  = 8'h80;   // self-test code produced
  localparam logic [7:0]  CODE_FULL       = 8'hFF;   // clamp above upper reference
  localparam logic [7:0]  CODE_ZERO       = 8'h00;   // clamp below lower reference
  localparam logic [7:0]  RESULT_RESET    = 8'h00;   // result after reset
  localparam int unsigned HOST_HALF_CLKS  = 8;       // host serial clock half period
  localparam int unsigned CS_SETUP_CLKS   = 256;     // host wait after chip select falls
  localparam int unsigned HOST_WAIT_CLKS  = CONV_CYCLES + 16; // host wait after 8th pulse
endpackage

// ---- hw/sac_sync.sv ----
// sac_sync: two-flop synchroniser for a level from another domain.
// assumes the input is a plain level; only the second flop is read outside.
`timescale 1ns/100ps
module sac_sync (
  input  wire logic clock,   // system clock
  input  wire logic sys_rst, // async reset, active high
  input  wire logic din,     // asynchronous level
  output logic      dout     // synchronised level
);
  logic meta; // first stage, read only by the second
  // two stages; reset value high suits idle-high link lines
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
